// >>> hw/wake_power_pkg.sv
// constants of the link wake and power sequencer
//
// Contract
// - self-test end leaves test mode
// - pass flag holds until new test or powerdown
// - pass flag reads high after powerdown toggle
// - serializer starts in standby after power-up
// - wake signal moves serializer to active
// - serializer uses pixel clock when present, else oscillator, in every state
// - clearing wake bit returns serializer to standby
// - powered-down serializer holds link outputs high
// - serializer auto bit unused, oscillator chosen whenever pixel clock absent
// - deserializer auto mode sleeps without stream
// - powered-down outputs follow output state select
// - equaliser level and line monitor by register
// - staggered outputs enabled by register
// - spread spectrum programmable by register
// - serializer latch edge follows its select bit
// - deserializer strobe edge follows its select bit
package wake_power_pkg;
   // ==========================================
   // register indices, byte address is four times
   localparam logic [7:0] IDX_REMOTE_WAKE = 8'h01;
   localparam logic [7:0] IDX_DRV_MODE = 8'h26;
   localparam logic [7:0] IDX_DRV_NORMAL = 8'h27;
   localparam logic [7:0] IDX_CONFIG = 8'h30;
   localparam logic [7:0] IDX_STATUS = 8'h31;
   // ==========================================
   // fields
   localparam int REMOTE_WAKE_BIT = 2;
   localparam logic [7:0] DRV_WAKE_MODE = 8'hc0;
   localparam int CFG_EQ_LSB = 0;
   localparam int CFG_LINE_MON = 3;
   localparam int CFG_POWERDOWN_OUTPUT_STATE_SELECT = 4;
   localparam int CFG_STAGGER = 5;
   localparam int CFG_SSC_EN = 6;
   localparam int CFG_SSC_RATE_LSB = 7;
   localparam int CFG_SSC_DEV_LSB = 10;
   localparam int CFG_TX_EDGE = 12;
   localparam int CFG_RX_EDGE = 13;
   localparam int CFG_SER_AUTO = 14;
   localparam int CFG_DES_AUTO = 15;
   // ==========================================
   // reset values
   localparam logic [7:0] REMOTE_WAKE_RST = 8'h00;
   localparam logic [7:0] DRV_MODE_RST = 8'h00;
   localparam logic [7:0] DRV_NORMAL_RST = 8'h00;
   localparam logic [15:0] CONFIG_RST = 16'h3000;
   localparam logic [5:0] PIN_RST = 6'h00;
   // ==========================================
   // bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ==========================================
   // serializer power states, gray along the path
   typedef enum logic [1:0] {
      SER_OFF = 2'h0,
      SER_STANDBY = 2'h1,
      SER_ACTIVE = 2'h3
   } ser_state_e;
endpackage

// >>> hw/wake_power_control.sv
// link wake, powerdown and self-test flag control with register slave
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module wake_power_control #(
   parameter int EQ_W = 3
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // axi4-lite write address and data
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // pins from outside
   input wire logic power_down_input_n,
   input wire logic pclk_present,
   input wire logic stream_present,
   input wire logic wake_detect,
   input wire logic link_self_test_en,
   input wire logic link_self_test_error,
   // serializer side
   output logic wake_send,
   output logic ser_standby,
   output logic ser_use_osc,
   output logic ser_link_out_high,
   output logic tx_latch_edge_select,
   // deserializer side
   output logic des_powered,
   output logic des_lock,
   output logic des_out_force,
   output logic des_out_level,
   output logic self_test_active,
   output logic self_test_pass,
   output logic rx_strobe_edge_select,
   // signal quality controls
   output logic [EQ_W-1:0] eq_level,
   output logic line_monitor_output_en,
   output logic stagger_en,
   output logic spread_spectrum_modulator_en,
   output logic [2:0] ssc_rate,
   output logic [1:0] ssc_dev
);
   // ==========================================
   // pin synchronisers
   logic [5:0] pin_raw;
   logic [5:0] pin_s1_reg;
   logic [5:0] pin_s2_reg;
   logic [5:0] pin_s3_reg;
   logic [5:0] pin_f_reg;
   logic pdb_f;
   logic pclk_f;
   logic stream_f;
   logic wake_f;
   logic test_en_f;
   logic test_err_f;

   assign pin_raw = {link_self_test_error, link_self_test_en, wake_detect,
      stream_present, pclk_present, power_down_input_n};
   assign pdb_f = pin_f_reg[0];
   assign pclk_f = pin_f_reg[1];
   assign stream_f = pin_f_reg[2];
   assign wake_f = pin_f_reg[3];
   assign test_en_f = pin_f_reg[4];
   assign test_err_f = pin_f_reg[5];

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         pin_s1_reg <= wake_power_pkg::PIN_RST;
         pin_s2_reg <= wake_power_pkg::PIN_RST;
         pin_s3_reg <= wake_power_pkg::PIN_RST;
         pin_f_reg <= wake_power_pkg::PIN_RST;
      end else begin
         pin_s1_reg <= pin_raw;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
         for (int i = 0; i < 6; i++) begin
            if (pin_s2_reg[i] == pin_s3_reg[i]) begin
               pin_f_reg[i] <= pin_s3_reg[i];
            end
         end
      end
   end

   // ==========================================
   // register slave
   logic [7:0] remote_wake_control_reg;
   logic [7:0] control_channel_driver_mode_reg;
   logic [7:0] control_channel_driver_normal_reg;
   logic [15:0] config_reg;
   logic [7:0] wr_idx;
   logic [7:0] rd_idx;
   logic wr_fire;
   logic wr_hit;
   logic [31:0] rd_data;
   logic rd_hit;
   logic [7:0] status_byte;

   assign wr_idx = s_axi_awaddr[9:2];
   assign rd_idx = s_axi_araddr[9:2];
   assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
      && !s_axi_awready;
   assign wr_hit = (s_axi_awaddr[31:10] == 22'h0)
      && (s_axi_awaddr[1:0] == 2'h0)
      && (wr_idx == wake_power_pkg::IDX_REMOTE_WAKE
      || wr_idx == wake_power_pkg::IDX_DRV_MODE
      || wr_idx == wake_power_pkg::IDX_DRV_NORMAL
      || wr_idx == wake_power_pkg::IDX_CONFIG);

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= wake_power_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= wr_fire;
         s_axi_wready <= wr_fire;
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? wake_power_pkg::RESP_OKAY
               : wake_power_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         remote_wake_control_reg <= wake_power_pkg::REMOTE_WAKE_RST;
         control_channel_driver_mode_reg <= wake_power_pkg::DRV_MODE_RST;
         control_channel_driver_normal_reg <= wake_power_pkg::DRV_NORMAL_RST;
         config_reg <= wake_power_pkg::CONFIG_RST;
      end else if (wr_fire && wr_hit) begin
         if (wr_idx == wake_power_pkg::IDX_REMOTE_WAKE && s_axi_wstrb[0]) begin
            remote_wake_control_reg <= s_axi_wdata[7:0];
         end
         if (wr_idx == wake_power_pkg::IDX_DRV_MODE && s_axi_wstrb[0]) begin
            control_channel_driver_mode_reg <= s_axi_wdata[7:0];
         end
         if (wr_idx == wake_power_pkg::IDX_DRV_NORMAL && s_axi_wstrb[0]) begin
            control_channel_driver_normal_reg <= s_axi_wdata[7:0];
         end
         if (wr_idx == wake_power_pkg::IDX_CONFIG) begin
            if (s_axi_wstrb[0]) begin
               config_reg[7:0] <= s_axi_wdata[7:0];
            end
            if (s_axi_wstrb[1]) begin
               config_reg[15:8] <= s_axi_wdata[15:8];
            end
         end
      end
   end

   wake_power_pkg::ser_state_e ser_state_reg;

   always_comb begin
      rd_hit = (s_axi_araddr[31:10] == 22'h0) && (s_axi_araddr[1:0] == 2'h0);
      rd_data = 32'h0;
      unique case (rd_idx)
         wake_power_pkg::IDX_REMOTE_WAKE: begin
            rd_data[7:0] = remote_wake_control_reg;
         end
         wake_power_pkg::IDX_DRV_MODE: begin
            rd_data[7:0] = control_channel_driver_mode_reg;
         end
         wake_power_pkg::IDX_DRV_NORMAL: begin
            rd_data[7:0] = control_channel_driver_normal_reg;
         end
         wake_power_pkg::IDX_CONFIG: begin
            rd_data[15:0] = config_reg;
         end
         wake_power_pkg::IDX_STATUS: begin
            rd_data[7:0] = status_byte;
         end
         default: begin
            rd_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= wake_power_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
         if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_hit ? rd_data : 32'h0;
            s_axi_rresp <= rd_hit ? wake_power_pkg::RESP_OKAY
               : wake_power_pkg::RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ==========================================
   // wake signalling and serializer power state
   logic rem_wake;
   logic rem_wake_prev_reg;
   logic rem_wake_fall;
   logic wake_mode;

   assign rem_wake = remote_wake_control_reg[wake_power_pkg::REMOTE_WAKE_BIT];
   assign rem_wake_fall = rem_wake_prev_reg && !rem_wake;
   assign wake_mode = control_channel_driver_mode_reg
      == wake_power_pkg::DRV_WAKE_MODE;

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         rem_wake_prev_reg <= 1'b0;
         wake_send <= 1'b0;
      end else begin
         rem_wake_prev_reg <= rem_wake;
         wake_send <= wake_mode && rem_wake;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         ser_state_reg <= wake_power_pkg::SER_OFF;
      end else if (!pdb_f) begin
         ser_state_reg <= wake_power_pkg::SER_OFF;
      end else begin
         unique case (ser_state_reg)
            wake_power_pkg::SER_OFF: begin
               ser_state_reg <= wake_power_pkg::SER_STANDBY;
            end
            wake_power_pkg::SER_STANDBY: begin
               if (wake_f) begin
                  ser_state_reg <= wake_power_pkg::SER_ACTIVE;
               end
            end
            wake_power_pkg::SER_ACTIVE: begin
               if (rem_wake_fall) begin
                  ser_state_reg <= wake_power_pkg::SER_STANDBY;
               end
            end
            default: begin
               ser_state_reg <= wake_power_pkg::SER_OFF;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         ser_standby <= 1'b1;
         ser_use_osc <= 1'b1;
         ser_link_out_high <= 1'b1;
      end else begin
         ser_standby <= ser_state_reg != wake_power_pkg::SER_ACTIVE;
         ser_use_osc <= !pclk_f;
         ser_link_out_high <= !pdb_f;
      end
   end

   // ==========================================
   // deserializer power, lock and powered-down outputs
   logic des_on;
   assign des_on = pdb_f && (!config_reg[wake_power_pkg::CFG_DES_AUTO]
      || stream_f);

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         des_powered <= 1'b0;
         des_lock <= 1'b0;
         des_out_force <= 1'b1;
         des_out_level <= 1'b0;
      end else begin
         des_powered <= des_on;
         des_lock <= des_on && stream_f;
         des_out_force <= !des_on;
         des_out_level <= !des_on && config_reg[wake_power_pkg::CFG_POWERDOWN_OUTPUT_STATE_SELECT];
      end
   end

   // ==========================================
   // self-test session and pass flag
   logic test_start;
   assign test_start = !self_test_active && test_en_f && des_lock;

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         self_test_active <= 1'b0;
         self_test_pass <= 1'b1;
      end else if (!pdb_f) begin
         self_test_active <= 1'b0;
         self_test_pass <= 1'b1;
      end else if (test_start) begin
         self_test_active <= 1'b1;
         self_test_pass <= 1'b1;
      end else if (self_test_active) begin
         self_test_active <= test_en_f;
         if (test_err_f && test_en_f) begin
            self_test_pass <= 1'b0;
         end
      end
   end

   assign status_byte = {1'b0, self_test_active, self_test_pass, des_lock,
      des_powered, ser_use_osc, ser_standby, wake_send};

   // ==========================================
   // signal quality and clock edge controls
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         eq_level <= '0;
         line_monitor_output_en <= 1'b0;
         stagger_en <= 1'b0;
         spread_spectrum_modulator_en <= 1'b0;
         ssc_rate <= 3'h0;
         ssc_dev <= 2'h0;
         tx_latch_edge_select <= 1'b1;
         rx_strobe_edge_select <= 1'b1;
      end else begin
         eq_level <= config_reg[wake_power_pkg::CFG_EQ_LSB +: EQ_W];
         line_monitor_output_en <= config_reg[wake_power_pkg::CFG_LINE_MON];
         stagger_en <= config_reg[wake_power_pkg::CFG_STAGGER];
         spread_spectrum_modulator_en <=
            config_reg[wake_power_pkg::CFG_SSC_EN];
         ssc_rate <= config_reg[wake_power_pkg::CFG_SSC_RATE_LSB +: 3];
         ssc_dev <= config_reg[wake_power_pkg::CFG_SSC_DEV_LSB +: 2];
         tx_latch_edge_select <=
            config_reg[wake_power_pkg::CFG_TX_EDGE];
         rx_strobe_edge_select <=
            config_reg[wake_power_pkg::CFG_RX_EDGE];
      end
   end

   // ==========================================
   // assertions
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   AST_TEST_EXIT: assert property (
      self_test_active && pdb_f && !test_en_f |=> !self_test_active)
      else $error("self-test did not end");
   AST_PASS_HOLD: assert property (
      pdb_f && !self_test_active && !test_start |=> $stable(self_test_pass))
      else $error("pass flag changed idle");
   AST_PASS_DEFAULT: assert property (!pdb_f ##1 pdb_f
      |-> self_test_pass) else $error("pass flag not high after toggle");
   AST_STANDBY_FIRST: assert property (
      ser_state_reg == wake_power_pkg::SER_OFF && pdb_f
      |=> ser_state_reg == wake_power_pkg::SER_STANDBY ##1 ser_standby)
      else $error("no standby after power-up");
   AST_WAKE: assert property (
      ser_state_reg == wake_power_pkg::SER_STANDBY && pdb_f && wake_f
      |=> ##1 !ser_standby) else $error("wake missed");
   AST_OSC: assert property (ser_use_osc == !$past(pclk_f))
      else $error("clock source wrong");
   AST_SLEEP: assert property (
      ser_state_reg == wake_power_pkg::SER_ACTIVE && rem_wake_fall && pdb_f
      |=> ##1 ser_standby) else $error("no sleep");
   AST_LINK_HIGH: assert property (!pdb_f |=> ser_link_out_high)
      else $error("link outputs not high");
   AST_DES_AUTO: assert property (
      config_reg[wake_power_pkg::CFG_DES_AUTO] && !stream_f
      |=> !des_powered && !des_lock) else $error("auto sleep");
   AST_OSS: assert property (!pdb_f |=> des_out_force
      && des_out_level == $past(config_reg[wake_power_pkg::CFG_POWERDOWN_OUTPUT_STATE_SELECT]))
      else $error("powered-down level wrong");
   AST_WAKE_SEND: assert property (
      wake_send |-> $past(wake_mode) && $past(rem_wake))
      else $error("wake sent outside wake mode");
   AST_EDGE: assert property (tx_latch_edge_select
      == $past(config_reg[wake_power_pkg::CFG_TX_EDGE])) else $error("edge");

   COV_WAKE: cover property (ser_state_reg == wake_power_pkg::SER_STANDBY
      ##1 ser_state_reg == wake_power_pkg::SER_ACTIVE);
   COV_SLEEP: cover property (ser_state_reg == wake_power_pkg::SER_ACTIVE
      ##1 ser_state_reg == wake_power_pkg::SER_STANDBY);
   COV_FAIL: cover property (self_test_active && !self_test_pass);
endmodule
`default_nettype wire

// >>> test/link_partner.sv
// remote serializer model answering the wake signal across the link
`timescale 1ns/1ps
`default_nettype none
module link_partner #(
   parameter logic SER_MODE = 1'b0,
   parameter logic DES_MODE = 1'b1
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // link side
   input wire logic wake_send,
   input wire logic slow,
   output logic wake_detect
);
   logic [4:0] wait_reg;
   // wake only recognised with camera strapping
   wire logic camera = (SER_MODE == 1'b0) && (DES_MODE == 1'b1);
   always_ff @(posedge ref_clk) begin
      if (!reset_n || !wake_send || !camera) begin
         wait_reg <= 5'h00;
         wake_detect <= 1'b0;
      end else if (wait_reg == (slow ? 5'h14 : 5'h02)) begin
         wake_detect <= 1'b1;
      end else begin
         wait_reg <= wait_reg + 5'h01;
      end
   end
endmodule
`default_nettype wire

// >>> test/test_wake_power_control.sv
// self-checking bench of the link wake and power sequencer
`timescale 1ns/1ps
`default_nettype none
module test_wake_power_control;
   // ==========================================
   // signals
   localparam logic [1:0] OK = wake_power_pkg::RESP_OKAY;
   localparam logic [1:0] ERR = wake_power_pkg::RESP_SLVERR;
   localparam logic [7:0] WM = wake_power_pkg::DRV_WAKE_MODE;
   localparam logic [31:0] A_WAKE =
      {22'h0, wake_power_pkg::IDX_REMOTE_WAKE, 2'h0};
   localparam logic [31:0] A_MODE =
      {22'h0, wake_power_pkg::IDX_DRV_MODE, 2'h0};
   localparam logic [31:0] A_NORM =
      {22'h0, wake_power_pkg::IDX_DRV_NORMAL, 2'h0};
   localparam logic [31:0] A_CFG = {22'h0, wake_power_pkg::IDX_CONFIG, 2'h0};
   localparam logic [31:0] A_STAT = {22'h0, wake_power_pkg::IDX_STATUS, 2'h0};
   logic ref_clk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, slow;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, ssc_dev;
   logic power_down_input_n, pclk_present, stream_present, wake_detect;
   logic link_self_test_en, link_self_test_error, wake_send, ser_standby;
   logic ser_use_osc, ser_link_out_high, tx_latch_edge_select, des_powered;
   logic des_lock, des_out_force, des_out_level, self_test_active;
   logic self_test_pass, rx_strobe_edge_select, line_monitor_output_en;
   logic stagger_en, spread_spectrum_modulator_en;
   logic [2:0] eq_level, ssc_rate;
   logic [31:0] d;
   logic [15:0] v;
   logic p;
   int i, errors, checks, cycles;
   wake_power_control dut (.*);
   link_partner partner (.ref_clk(ref_clk), .reset_n(reset_n),
      .wake_send(wake_send), .slow(slow), .wake_detect(wake_detect));
   // ==========================================
   // helpers
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   task automatic summarize();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         errors++;
         summarize();
      end
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] w,
         input logic [1:0] er);
      int n;
      logic b;
      @(posedge ref_clk);
      b = 1'b0;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= w;
      s_axi_wstrb <= 4'hf;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; !b; n++) begin
         @(posedge ref_clk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) begin
            b = 1'b1;
            s_axi_bready <= 1'b0;
            chk(s_axi_bresp, er);
         end
      end
      chk(n, 2);
   endtask
   task automatic rd(input logic [31:0] a, output logic [31:0] r,
         input logic [1:0] er);
      int n;
      logic b;
      @(posedge ref_clk);
      b = 1'b0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; !b; n++) begin
         @(posedge ref_clk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) begin
            b = 1'b1;
            r = s_axi_rdata;
            s_axi_rready <= 1'b0;
            chk(s_axi_rresp, er);
         end
      end
      chk(n, 2);
   endtask
   function automatic logic wake_exp(input logic [7:0] m, input logic [7:0] c);
      return m == WM && c[wake_power_pkg::REMOTE_WAKE_BIT];
   endfunction
   function automatic logic [12:0] cfg_out(input logic [15:0] c);
      return {c[wake_power_pkg::CFG_RX_EDGE], c[wake_power_pkg::CFG_TX_EDGE],
         c[11:10], c[9:7], c[6], c[5], c[3], c[2:0]};
   endfunction
   task automatic session(input logic err);
      link_self_test_en <= 1'b1;
      tick(8);
      chk(self_test_active, 1'b1);
      if (err) begin
         link_self_test_error <= 1'b1;
         tick(5);
         link_self_test_error <= 1'b0;
      end
      tick(4);
      link_self_test_en <= 1'b0;
      tick(8);
      chk(self_test_active, 1'b0);
      chk(self_test_pass, !err);
   endtask
   // ==========================================
   // main sequence
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid} = '0;
      {s_axi_rready, power_down_input_n, pclk_present, slow} = '0;
      {stream_present, link_self_test_en, link_self_test_error} = '0;
      {reset_n, errors, checks, cycles} = '0;
      void'($urandom(32'h7cea));
      tick(2);
      reset_n <= 1'b1;
      chk({ser_standby, ser_use_osc, ser_link_out_high, des_out_force,
         self_test_pass, tx_latch_edge_select, rx_strobe_edge_select},
         7'h7f);
      rd(A_WAKE, d, OK);
      chk(d, wake_power_pkg::REMOTE_WAKE_RST);
      rd(A_MODE, d, OK);
      chk(d, wake_power_pkg::DRV_MODE_RST);
      rd(A_NORM, d, OK);
      chk(d, wake_power_pkg::DRV_NORMAL_RST);
      rd(A_CFG, d, OK);
      chk(d, wake_power_pkg::CONFIG_RST);
      rd(32'h100, d, ERR);
      chk(d, 32'h0);
      wr(A_STAT, 32'h0, ERR);
      power_down_input_n <= 1'b1;
      tick(8);
      chk({ser_standby, ser_link_out_high}, 2'b10);
      $display("test reset done");
      wr(A_WAKE, 32'h4, OK);
      tick(2);
      chk(wake_send, wake_exp(8'h00, 8'h04));
      tick(30);
      chk(ser_standby, 1'b1);
      wr(A_WAKE, 32'h0, OK);
      slow <= 1'($urandom % 2);
      wr(A_MODE, {24'h0, WM}, OK);
      wr(A_WAKE, 32'h4, OK);
      tick(2);
      chk(wake_send, wake_exp(WM, 8'h04));
      tick(40);
      chk(ser_standby, 1'b0);
      rd(A_STAT, d, OK);
      chk(d[1], 1'b0);
      for (i = 0; i < 4; i++) begin
         p = 1'($urandom % 2);
         pclk_present <= p;
         tick(8);
         chk(ser_use_osc, !p);
      end
      wr(A_MODE, 32'h0, OK);
      tick(2);
      chk(wake_send, 1'b0);
      wr(A_NORM, {24'h0, WM}, OK);
      rd(A_NORM, d, OK);
      chk(d, {24'h0, WM});
      chk(ser_standby, 1'b0);
      wr(A_WAKE, 32'h0, OK);
      tick(4);
      chk(ser_standby, 1'b1);
      $display("test wake done");
      for (i = 0; i < 6; i++) begin
         v = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : 16'($urandom);
         wr(A_CFG, {16'h0, v}, OK);
         rd(A_CFG, d, OK);
         chk(d, {16'h0, v});
         chk({rx_strobe_edge_select, tx_latch_edge_select, ssc_dev, ssc_rate,
            spread_spectrum_modulator_en, stagger_en, line_monitor_output_en,
            eq_level}, cfg_out(v));
      end
      $display("test config done");
      for (i = 0; i < 2; i++) begin
         wr(A_CFG, 32'hb000 | (i << 4), OK);
         stream_present <= 1'b0;
         tick(8);
         chk({des_powered, des_out_force, des_out_level},
            {2'b01, 1'(i)});
         stream_present <= 1'b1;
         tick(8);
         chk({des_powered, des_lock, des_out_force}, 3'b110);
      end
      $display("test auto done");
      wr(A_CFG, 32'h3000, OK);
      tick(8);
      chk(des_lock, 1'b1);
      session(1'b1);
      tick(30);
      chk(self_test_pass, 1'b0);
      session(1'b0);
      session(1'b1);
      power_down_input_n <= 1'b0;
      tick(8);
      chk({ser_link_out_high, ser_standby, des_out_force}, 3'b111);
      power_down_input_n <= 1'b1;
      tick(8);
      chk({self_test_pass, ser_standby}, 2'b11);
      rd(A_STAT, d, OK);
      chk(d[5], 1'b1);
      $display("test self test done");
      summarize();
   end
endmodule
`default_nettype wire
